// file: hw/lsw_pkg.sv
// Package for the level switch cyclic status block: register map, codes, timing
package lsw_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0] LSW_OFF_CTRL   = 8'h00;
   localparam logic [7:0] LSW_OFF_ADDR   = 8'h04;
   localparam logic [7:0] LSW_OFF_LOLIM  = 8'h08;
   localparam logic [7:0] LSW_OFF_HILIM  = 8'h0C;
   localparam logic [7:0] LSW_OFF_CONN   = 8'h10;
   localparam logic [7:0] LSW_OFF_OUT    = 8'h14;
   localparam logic [7:0] LSW_OFF_IRQST  = 8'h18;
   localparam logic [7:0] LSW_OFF_IRQMSK = 8'h1C;
   localparam logic [7:0] LSW_OFF_STAT   = 8'h20;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int LSW_CTRL_INVERT    = 0;
   localparam int LSW_CTRL_CONDENSED = 1;
   localparam int LSW_CTRL_NUMERIC   = 2;
   localparam int LSW_CTRL_PARAM_CHG = 3;  // Write 1: behaviour-relevant change
   localparam logic [2:0] LSW_CTRL_RESET = 3'h2;  // Condensed status on

   // ------------------------------------------------------------
   // Node address
   // ------------------------------------------------------------
   localparam logic [6:0] LSW_ADDR_MAX   = 7'h7E;
   localparam logic [6:0] LSW_ADDR_RESET = 7'h7E;

   // ------------------------------------------------------------
   // Connection limits
   // ------------------------------------------------------------
   localparam logic [2:0] LSW_C2_MAX = 3'h4;

   // ------------------------------------------------------------
   // Status codes
   // ------------------------------------------------------------
   localparam logic [7:0] LSW_ST_BAD     = 8'h00;
   localparam logic [7:0] LSW_ST_INITIAL = 8'h4F;
   localparam logic [7:0] LSW_ST_GOOD    = 8'h80;
   localparam logic [7:0] LSW_ST_BLKALM  = 8'h84;
   localparam logic [7:0] LSW_ST_LO_LIM  = 8'h8D;
   localparam logic [7:0] LSW_ST_HI_LIM  = 8'h8E;

   // ------------------------------------------------------------
   // Interrupt bits
   // ------------------------------------------------------------
   localparam int LSW_IRQ_LO      = 0;
   localparam int LSW_IRQ_HI      = 1;
   localparam int LSW_IRQ_PARAM   = 2;
   localparam int LSW_IRQ_REFUSED = 3;
   localparam int LSW_IRQ_W       = 4;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint LSW_CLK_HZ      = 100000000;
   localparam longint LSW_ALARM_MS    = 10000;
   localparam longint LSW_ALARM_CYC   = LSW_ALARM_MS * (LSW_CLK_HZ / 1000);

   // Cyclic output frame
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] status;
   } lsw_frame_t;

   // Local keypad address request
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
   } lsw_addr_req_t;
endpackage

// file: hw/lsw_top.sv
// Level switch cyclic output logic with Avalon-MM register slave
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/10ps

module lsw_top
   import lsw_pkg::*;
#(
   parameter int          CNT_W     = 16,
   parameter longint      ALARM_CYC = lsw_pkg::LSW_ALARM_CYC
) (
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   // Avalon-MM slave
   input  wire logic [7:0]             avs_address_in,
   input  wire logic                   avs_read_in,
   input  wire logic                   avs_write_in,
   input  wire logic [31:0]            avs_writedata_in,
   input  wire logic [3:0]             avs_byteenable_in,
   output logic [31:0]                 avs_readdata_out,
   output logic                        avs_waitrequest_out,
   // Sensor side
   input  wire logic                   sensor_valid_in,
   input  wire logic                   sensor_covered_in,
   input  wire logic [CNT_W-1:0]       sensor_count_in,
   input  wire logic                   sensor_fault_in,
   // Local keypad address request
   input  wire lsw_pkg::lsw_addr_req_t local_addr_in,
   // Connection requests (one-cycle pulses) and the cyclic_run_in level
   input  wire logic                   c1_open_in,
   input  wire logic                   c1_close_in,
   input  wire logic                   c2_open_in,
   input  wire logic                   c2_close_in,
   input  wire logic                   cyclic_run_in,
   // Cyclic exchange
   input  wire logic                   scan_in,
   output lsw_pkg::lsw_frame_t         frame_out,
   output logic                        frame_valid_out,
   // Local indication and connection status
   output logic                        disp_numeric_out,
   output logic                        disp_alarm_out,
   output logic [6:0]                  node_addr_out,
   output logic                        c1_open_out,
   output logic [2:0]                  c2_count_out,
   // Interrupt
   output logic                        irq_out
);
   import lsw_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [2:0]          ctrl_q;
   logic [6:0]          addr_q;
   logic [CNT_W-1:0]    lolim_q, hilim_q;
   logic                c1_q;
   logic [2:0]          c2_q;
   logic                measured_q;
   logic [63:0]         alarm_cnt_q;
   logic                blkalm_q;
   logic [LSW_IRQ_W-1:0] irq_st_q, irq_msk_q;
   logic                ack_q;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire acc      = (avs_read_in | avs_write_in) & ~ack_q;
   // Writes land on the edge that sees waitrequest low, never on the taking edge
   wire wr       = avs_write_in & ack_q & avs_byteenable_in[0];
   wire wr_ctrl  = wr & (avs_address_in == LSW_OFF_CTRL);
   wire wr_addr  = wr & (avs_address_in == LSW_OFF_ADDR);
   wire wr_lo    = wr & (avs_address_in == LSW_OFF_LOLIM);
   wire wr_hi    = wr & (avs_address_in == LSW_OFF_HILIM);
   wire wr_irqst = wr & (avs_address_in == LSW_OFF_IRQST);
   wire wr_irqmk = wr & (avs_address_in == LSW_OFF_IRQMSK);
   wire [6:0] bus_addr = avs_writedata_in[6:0];

   // ------------------------------------------------------------
   // Address acceptance
   // ------------------------------------------------------------
   wire bus_addr_ok = wr_addr & (avs_writedata_in[31:7] == 25'h0)
                      & (bus_addr <= LSW_ADDR_MAX);
   wire loc_ok      = local_addr_in.valid & (local_addr_in.addr <= LSW_ADDR_MAX)
                      & ~cyclic_run_in;
   wire addr_refused = (local_addr_in.valid & ~loc_ok) | (wr_addr & ~bus_addr_ok);

   // ------------------------------------------------------------
   // Connection accounting
   // ------------------------------------------------------------
   wire c1_open_ok  = c1_open_in & ~c1_q;
   wire c2_open_ok  = c2_open_in & ~c2_close_in & (c2_q < LSW_C2_MAX);
   wire c2_close_ok = c2_close_in & ~c2_open_in & (c2_q != 3'h0);
   wire conn_refused = (c1_open_in & c1_q)
                       | (c2_open_in & ~c2_close_in & (c2_q == LSW_C2_MAX));

   // ------------------------------------------------------------
   // Status selection, priority highest first
   // ------------------------------------------------------------
   wire below = sensor_count_in < lolim_q;
   wire above = sensor_count_in > hilim_q;
   wire param_chg = wr_ctrl & avs_writedata_in[LSW_CTRL_PARAM_CHG];
   logic [7:0] status_c;
   always_comb begin
      if (sensor_fault_in)
         status_c = LSW_ST_BAD;
      else if (!measured_q)
         status_c = LSW_ST_INITIAL;
      else if (below)
         status_c = LSW_ST_LO_LIM;
      else if (above)
         status_c = LSW_ST_HI_LIM;
      else if (blkalm_q)
         status_c = LSW_ST_BLKALM;
      else
         status_c = LSW_ST_GOOD;
   end
   // Non-condensed form keeps only the quality bits, substatus dropped
   wire [7:0] status_sel = ctrl_q[LSW_CTRL_CONDENSED] ? status_c
                           : {status_c[7:6], 6'h00};
   wire       level_c = sensor_covered_in ^ ctrl_q[LSW_CTRL_INVERT];

   // ------------------------------------------------------------
   // Interrupt events
   // ------------------------------------------------------------
   wire [LSW_IRQ_W-1:0] irq_ev = {addr_refused | conn_refused, param_chg,
                                  measured_q & above, measured_q & below};
   wire [LSW_IRQ_W-1:0] irq_clr = wr_irqst ? avs_writedata_in[LSW_IRQ_W-1:0]
                                  : '0;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic [31:0] rd_c;
   always_comb begin
      unique case (avs_address_in)
         LSW_OFF_CTRL:   rd_c = {29'h0, ctrl_q};
         LSW_OFF_ADDR:   rd_c = {25'h0, addr_q};
         LSW_OFF_LOLIM:  rd_c = 32'(lolim_q);
         LSW_OFF_HILIM:  rd_c = 32'(hilim_q);
         LSW_OFF_CONN:   rd_c = {27'h0, c2_q, 1'b0, c1_q};
         LSW_OFF_OUT:    rd_c = {16'h0, 7'h00, level_c, status_sel};
         LSW_OFF_IRQST:  rd_c = {28'h0, irq_st_q};
         LSW_OFF_IRQMSK: rd_c = {28'h0, irq_msk_q};
         LSW_OFF_STAT:   rd_c = {30'h0, blkalm_q, measured_q};
         default:        rd_c = 32'h0;
      endcase
   end

   // ------------------------------------------------------------
   // Bus handshake: one wait cycle, answer on the second edge
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ack_q               <= 1'b0;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0;
      end else begin
         ack_q               <= acc;
         avs_waitrequest_out <= ~acc;
         avs_readdata_out    <= acc ? rd_c : 32'h0;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl_q  <= LSW_CTRL_RESET;
         addr_q  <= LSW_ADDR_RESET;
         lolim_q <= '0;
         hilim_q <= '1;
      end else begin
         if (wr_ctrl)
            ctrl_q <= avs_writedata_in[2:0];
         if (bus_addr_ok)
            addr_q <= bus_addr;
         else if (loc_ok)
            addr_q <= local_addr_in.addr;
         if (wr_lo)
            lolim_q <= avs_writedata_in[CNT_W-1:0];
         if (wr_hi)
            hilim_q <= avs_writedata_in[CNT_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Connections
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         c1_q <= 1'b0;
         c2_q <= 3'h0;
      end else begin
         if (c1_open_ok)
            c1_q <= 1'b1;
         else if (c1_close_in)
            c1_q <= 1'b0;
         if (c2_open_ok)
            c2_q <= c2_q + 3'h1;
         else if (c2_close_ok)
            c2_q <= c2_q - 3'h1;
      end
   end

   // ------------------------------------------------------------
   // Measurement and block alarm timer
   // ------------------------------------------------------------
   // Counter is wide so simulation can shorten it via ALARM_CYC only
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         measured_q  <= 1'b0;
         blkalm_q    <= 1'b0;
         alarm_cnt_q <= 64'h0;
      end else begin
         if (sensor_valid_in)
            measured_q <= 1'b1;
         if (param_chg) begin
            blkalm_q    <= 1'b1;
            alarm_cnt_q <= 64'(ALARM_CYC - 1);
         end else if (blkalm_q) begin
            if (alarm_cnt_q == 64'h0)
               blkalm_q <= 1'b0;
            else
               alarm_cnt_q <= alarm_cnt_q - 64'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Cyclic frame: both bytes latched on one edge
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         frame_out       <= '{level: 8'h00, status: LSW_ST_INITIAL};
         frame_valid_out <= 1'b0;
      end else begin
         frame_valid_out <= scan_in;
         if (scan_in)
            frame_out <= '{level: {7'h00, level_c}, status: status_sel};
      end
   end

   // ------------------------------------------------------------
   // Interrupts and indications; set wins over clear
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         irq_st_q         <= '0;
         irq_msk_q        <= '0;
         irq_out          <= 1'b0;
         disp_numeric_out <= 1'b0;
         disp_alarm_out   <= 1'b0;
         node_addr_out    <= LSW_ADDR_RESET;
         c1_open_out      <= 1'b0;
         c2_count_out     <= 3'h0;
      end else begin
         irq_st_q  <= (irq_st_q & ~irq_clr) | irq_ev;
         if (wr_irqmk)
            irq_msk_q <= avs_writedata_in[LSW_IRQ_W-1:0];
         irq_out          <= |(irq_st_q & irq_msk_q);
         disp_numeric_out <= ctrl_q[LSW_CTRL_NUMERIC];
         disp_alarm_out   <= blkalm_q;
         node_addr_out    <= addr_q;
         c1_open_out      <= c1_q;
         c2_count_out     <= c2_q;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   addr_range_a: assert property (@(posedge clk_in) disable iff (rst_in)
      addr_q <= LSW_ADDR_MAX) else $error("node address out of range");
   addr_reset_a: assert property (@(posedge clk_in)
      rst_in |=> addr_q == LSW_ADDR_RESET) else $error("address reset wrong");
   local_lock_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (cyclic_run_in && local_addr_in.valid && !wr_addr) |=> $stable(addr_q))
      else $error("local address change during cyclic exchange");
   c2_limit_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (c2_q == LSW_C2_MAX && c2_open_in && !c2_close_in) |=> c2_q == LSW_C2_MAX)
      else $error("fifth class 2 connection accepted");
   c1_single_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (c1_q && !c1_close_in) |=> c1_q) else $error("class 1 lost");
   frame_scan_a: assert property (@(posedge clk_in) disable iff (rst_in)
      scan_in |=> frame_valid_out && frame_out.level[7:1] == 7'h00)
      else $error("frame not delivered");
   level_inv_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && !ctrl_q[LSW_CTRL_INVERT])
      |=> frame_out.level[0] == $past(sensor_covered_in)) else $error("level byte wrong");
   level_flip_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && ctrl_q[LSW_CTRL_INVERT])
      |=> frame_out.level[0] != $past(sensor_covered_in)) else $error("inverted level");
   lolim_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && measured_q && !sensor_fault_in && below && ctrl_q[1])
      |=> frame_out.status == LSW_ST_LO_LIM) else $error("underflow code");
   hilim_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && measured_q && !sensor_fault_in && ctrl_q[LSW_CTRL_CONDENSED]
       && sensor_count_in >= lolim_q && sensor_count_in > hilim_q)
      |=> frame_out.status == LSW_ST_HI_LIM) else $error("overflow code");
   fault_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && sensor_fault_in) |=> frame_out.status == LSW_ST_BAD)
      else $error("fault code");
   good_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && measured_q && !sensor_fault_in && !blkalm_q && ctrl_q[LSW_CTRL_CONDENSED]
       && sensor_count_in >= lolim_q && sensor_count_in <= hilim_q)
      |=> frame_out.status == LSW_ST_GOOD) else $error("good code");
   blkalm_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && measured_q && !sensor_fault_in && blkalm_q && ctrl_q[LSW_CTRL_CONDENSED]
       && sensor_count_in >= lolim_q && sensor_count_in <= hilim_q)
      |=> frame_out.status == LSW_ST_BLKALM) else $error("block alarm code");
   plain_form_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && !ctrl_q[LSW_CTRL_CONDENSED]) |=> frame_out.status[5:0] == 6'h00)
      else $error("substatus kept with condensed form off");
   blk_alarm_a: assert property (@(posedge clk_in) disable iff (rst_in)
      param_chg |=> blkalm_q [*2]) else $error("block alarm missing");
   alarm_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (blkalm_q && alarm_cnt_q == 64'h0 && !param_chg) |=> !blkalm_q)
      else $error("block alarm outlasts its hold time");
   irq_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (irq_ev != '0) |=> (irq_st_q & $past(irq_ev)) == $past(irq_ev))
      else $error("event lost to a clear");
   disp_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_ctrl |=> ##1 disp_numeric_out == $past(avs_writedata_in[LSW_CTRL_NUMERIC], 2))
      else $error("display mode not followed");
   initial_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (scan_in && !measured_q && !sensor_fault_in && ctrl_q[1])
      |=> frame_out.status == LSW_ST_INITIAL) else $error("initial code");
endmodule

// file: tb/lsw_master_model.sv
// Cyclic master model: issues bus scans and fetches the two-byte frame whole
`timescale 1ns/10ps
module lsw_master_model (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   // Bench command and result
   input  wire logic                go_in,
   output logic                     got_out,
   output lsw_pkg::lsw_frame_t      cap_out,
   // Block side
   output logic                     scan_out,
   input  wire lsw_pkg::lsw_frame_t frame_in,
   input  wire logic                frame_valid_in
);
   import lsw_pkg::*;
   // Scan on command; both bytes latched on one edge, never byte by byte
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         scan_out <= 1'b0;
         got_out  <= 1'b0;
         cap_out  <= '0;
      end else begin
         scan_out <= go_in;
         if (go_in) begin
            got_out <= 1'b0;
         end else if (frame_valid_in) begin
            cap_out <= frame_in;
            got_out <= 1'b1;
         end
      end
   end
endmodule

// file: tb/tb_lsw_top.sv
// Testbench for the level switch cyclic status block
`timescale 1ns/10ps
module tb_lsw_top;
   import lsw_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int ALARM = 20;     // Shortened alarm hold keeps the run brief
   localparam int LIMIT = 20000;  // Cycle ceiling for the whole run
   logic          clk_in, rst_in, av_rd, av_wr, av_wait, sens_valid, sens_cov, sens_fault;
   logic [7:0]    av_addr;
   logic [31:0]   av_wdata, av_rdata, rdq;
   logic [15:0]   sens_cnt;
   lsw_addr_req_t local_req;
   logic          c1_open, c1_close, c2_open, c2_close, cyc_run, scan, frame_valid, go, got;
   lsw_frame_t    frame, cap;
   logic          disp_num, disp_alm, c1_st, irq;
   logic [6:0]    node_addr;
   logic [2:0]    c2_cnt;
   int            n_errors, total_checks, cycles;

   lsw_top #(.CNT_W(16), .ALARM_CYC(ALARM)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(av_addr), .avs_read_in(av_rd),
      .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_byteenable_in(4'hF),
      .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
      .sensor_valid_in(sens_valid), .sensor_covered_in(sens_cov),
      .sensor_count_in(sens_cnt), .sensor_fault_in(sens_fault), .local_addr_in(local_req),
      .c1_open_in(c1_open), .c1_close_in(c1_close), .c2_open_in(c2_open),
      .c2_close_in(c2_close), .cyclic_run_in(cyc_run), .scan_in(scan), .frame_out(frame),
      .frame_valid_out(frame_valid), .disp_numeric_out(disp_num),
      .disp_alarm_out(disp_alm), .node_addr_out(node_addr), .c1_open_out(c1_st),
      .c2_count_out(c2_cnt), .irq_out(irq));

   lsw_master_model u_master (
      .clk_in(clk_in), .rst_in(rst_in), .go_in(go), .got_out(got), .cap_out(cap),
      .scan_out(scan), .frame_in(frame), .frame_valid_in(frame_valid));

   // ------------------------------------------------------------
   // Clock, timeout and closing
   // ------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // A hung handshake must still reach the verdict
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      total_checks++;
      if (got_v !== exp_v) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      av_addr  <= a;
      av_rd    <= ~wr;
      av_wr    <= wr;
      av_wdata <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (av_wait !== 1'b0 && n < 50);
      if (n >= 50) n_errors++;
      rdq = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      av_xfer(1'b0, a, 32'h0);
      chk(rdq, e);
   endtask
   // One bus scan through the master model, frame compared whole
   task automatic scan_chk(input logic [15:0] e);
      int n;
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      // Let the model drop its old result before polling for the new one
      @(posedge clk_in);
      for (n = 0; n < 10 && got !== 1'b1; n++) @(posedge clk_in);
      chk(32'(got), 32'h1);
      chk(32'(cap), 32'(e));
   endtask
   task automatic set_cnt(input logic [15:0] c);
      sens_cnt <= c;
      cyc(2);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rst_in, av_rd, av_wr, sens_valid, sens_cov, sens_fault} = 6'b100000;
      {c1_open, c1_close, c2_open, c2_close, cyc_run, go} = 6'b0;
      av_addr = 8'h00;
      av_wdata = 32'h0;
      sens_cnt = 16'h0096;
      local_req = '0;
      cyc(5);
      rst_in <= 1'b0;
      cyc(1);
      rd_chk(LSW_OFF_CTRL, 32'h2);
      rd_chk(LSW_OFF_ADDR, 32'h7E);
      chk(32'(node_addr), 32'h7E);
      rd_chk(LSW_OFF_LOLIM, 32'h0);
      rd_chk(LSW_OFF_HILIM, 32'hFFFF);
      rd_chk(8'h30, 32'h0);
      scan_chk({8'h00, LSW_ST_INITIAL});
      sens_valid <= 1'b1;
      cyc(1);
      sens_valid <= 1'b0;
      cyc(2);
      scan_chk({8'h00, LSW_ST_GOOD});
      sens_cov <= 1'b1;
      cyc(2);
      scan_chk({8'h01, LSW_ST_GOOD});
      av_xfer(1'b1, LSW_OFF_CTRL, 32'h3);
      scan_chk({8'h00, LSW_ST_GOOD});
      sens_cov <= 1'b0;
      cyc(2);
      scan_chk({8'h01, LSW_ST_GOOD});
      av_xfer(1'b1, LSW_OFF_CTRL, 32'h2);
      // Limits in raw counts, both sides of the window
      av_xfer(1'b1, LSW_OFF_LOLIM, 32'd100);
      av_xfer(1'b1, LSW_OFF_HILIM, 32'd200);
      set_cnt(16'd50);
      scan_chk({8'h00, LSW_ST_LO_LIM});
      set_cnt(16'd300);
      scan_chk({8'h00, LSW_ST_HI_LIM});
      set_cnt(16'd50);
      av_xfer(1'b1, LSW_OFF_CTRL, 32'h0);
      scan_chk({8'h00, LSW_ST_LO_LIM & 8'hC0});
      set_cnt(16'd150);
      av_xfer(1'b1, LSW_OFF_CTRL, 32'h6);
      cyc(2);
      chk(32'(disp_num), 32'h1);
      av_xfer(1'b1, LSW_OFF_CTRL, 32'hA);
      cyc(2);
      chk(32'(disp_num), 32'h0);
      chk(32'(disp_alm), 32'h1);
      scan_chk({8'h00, LSW_ST_BLKALM});
      cyc(ALARM);
      scan_chk({8'h00, LSW_ST_GOOD});
      chk(32'(disp_alm), 32'h0);
      sens_fault <= 1'b1;
      cyc(2);
      scan_chk({8'h00, LSW_ST_BAD});
      sens_fault <= 1'b0;
      // Node address range and local change lockout
      av_xfer(1'b1, LSW_OFF_ADDR, 32'h7F);
      rd_chk(LSW_OFF_ADDR, 32'h7E);
      av_xfer(1'b1, LSW_OFF_ADDR, 32'h0);
      rd_chk(LSW_OFF_ADDR, 32'h0);
      cyc_run <= 1'b1;
      local_req <= '{valid: 1'b1, addr: 7'h05};
      cyc(1);
      local_req <= '0;
      cyc(2);
      rd_chk(LSW_OFF_ADDR, 32'h0);
      av_xfer(1'b1, LSW_OFF_ADDR, 32'h7E);
      rd_chk(LSW_OFF_ADDR, 32'h7E);
      cyc_run <= 1'b0;
      local_req <= '{valid: 1'b1, addr: 7'h05};
      cyc(1);
      local_req <= '0;
      cyc(2);
      rd_chk(LSW_OFF_ADDR, 32'h5);
      chk(32'(node_addr), 32'h5);
      // Connection limits, one refused request of each class
      repeat (5) begin
         c2_open <= 1'b1;
         cyc(1);
         c2_open <= 1'b0;
         cyc(1);
      end
      cyc(1);
      chk(32'(c2_cnt), 32'h4);
      c2_close <= 1'b1;
      cyc(1);
      c2_close <= 1'b0;
      repeat (2) begin
         c1_open <= 1'b1;
         cyc(1);
         c1_open <= 1'b0;
         cyc(1);
      end
      cyc(1);
      chk(32'(c1_st), 32'h1);
      rd_chk(LSW_OFF_CONN, 32'h0D);
      // Closing frees the single class 1 slot for a new master
      c1_close <= 1'b1;
      cyc(1);
      c1_close <= 1'b0;
      cyc(2);
      chk(32'(c1_st), 32'h0);
      c1_open <= 1'b1;
      cyc(1);
      c1_open <= 1'b0;
      cyc(2);
      chk(32'(c1_st), 32'h1);
      // Sticky status, mask and clear
      rd_chk(LSW_OFF_IRQST, 32'hF);
      chk(32'(irq), 32'h0);
      av_xfer(1'b1, LSW_OFF_IRQMSK, 32'h8);
      cyc(2);
      chk(32'(irq), 32'h1);
      av_xfer(1'b1, LSW_OFF_IRQST, 32'h8);
      cyc(2);
      chk(32'(irq), 32'h0);
      rd_chk(LSW_OFF_IRQST, 32'h7);
      finish_test();
   end
endmodule
